// File: fmr_map.vh
`ifndef FMR_MAP_VH
`define FMR_MAP_VH
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define FMR_CLK_HZ        250000000
`define FMR_BAUD          9600
`define FMR_OVS           16
`define FMR_TICK_DIV      (`FMR_CLK_HZ / (`FMR_BAUD * `FMR_OVS))
`define FMR_SILENCE_BITS  35
`define FMR_SILENCE_TICKS (`FMR_SILENCE_BITS * `FMR_OVS)
`define FMR_SYNC_WAIT     2'h3
// ----------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------
`define FMR_REG_RUN       16'h0001
`define FMR_REG_DEMAND    16'h0002
`define FMR_REG_RPM       16'h0006
`define FMR_REG_KNOB      16'h0007
`define FMR_REG_STATUS    16'h0009
`define FMR_REG_DEF_DEM   16'h000A
`define FMR_REG_APPLIED   16'h000C
`define FMR_REG_DEF_RUN   16'h000E
`define FMR_REG_EXT_V     16'h0018
// ----------------------------------------------------------------
// Reset values, limits and status fields
// ----------------------------------------------------------------
`define FMR_DEF_DEMAND    16'h0032
`define FMR_DEF_ENABLE    16'h0001
`define FMR_FACTORY_KEY   16'h00AA
`define FMR_MAX_PCT       16'h0064
`define FMR_MAX_RPM       16'h07D0
`define FMR_RPM_STEP      16'h0005
`define FMR_ST_LAMP       0
`define FMR_ST_RUN        1
`define FMR_ST_NET        2
`define FMR_ST_ANA        3
// ----------------------------------------------------------------
// External input scaling, 10 mV units
// ----------------------------------------------------------------
`define FMR_ANA_ON        10'h018
`define FMR_ANA_OFF       10'h013
`define FMR_ANA_FULL      10'h3DD
`define FMR_ANA_BASE      10'h016
`define FMR_ANA_SPAN      17'h003C7
`define FMR_ANA_GAIN      7'h62
// ----------------------------------------------------------------
// Protocol
// ----------------------------------------------------------------
`define FMR_FN_READ       8'h03
`define FMR_FN_WRITE      8'h06
`define FMR_EXC_FLAG      8'h80
`define FMR_EXC_FN        8'h01
`define FMR_EXC_ADDR      8'h02
`define FMR_EXC_VAL       8'h03
`define FMR_CRC_INIT      16'hFFFF
`define FMR_CRC_POLY      16'hA001
`define FMR_REQ_LEN       4'h8
`define FMR_EXC_LEN       8'h05
`endif

// File: fmr_core.v
`timescale 1ns/1ps
// How it works
// - Mode bits pick knob or analog source
// - Bit one set always means network mode
// - Knob mode: demand rises with knob reading
// - Analog mode: demand from external voltage
// - Network mode: demand from register 2
// - Eight switches give binary slave address
// - Address zero accepted as silent broadcast
// - Address switches latched at power-up, switch 0 also read live for test output
// - Register 1 enables or disables motor in network mode
// - Power-up loads registers 1,2 from defaults
// - Register 6 returns quantised motor speed
// - Register 7 returns knob reading 0-1000
// - Register 24 returns external voltage reading
// - Register 12 returns applied drive level
// - Registers 10,14 nonvolatile, factory 50 and 1
// - Key 170 in 14 restores factory defaults
// - Link 9600 baud, 8 bits, no parity
// - Analog hysteresis 240/190 mV, scaled to 9.89 V
// - Speed in 5 rpm steps up to 2000
// - Test output selects demand or speed
// - Status lamps lit while speed at least 5 rpm
// - Line lamp follows receive line
`include "fmr_map.vh"
module fmr_core #(
  parameter TICK_DIV   = `FMR_TICK_DIV,
  parameter SIL_TICKS  = `FMR_SILENCE_TICKS,
  parameter QMAX       = 16
) (
  input  wire        clk_sys_i,
  input  wire        reset_n_i,
  input  wire [1:0]  mode_switch_bank_i,
  input  wire [7:0]  address_switch_bank_i,
  input  wire [9:0]  knob_reading_i,
  input  wire [9:0]  external_voltage_reading_i,
  input  wire [15:0] motor_rpm_i,
  input  wire [15:0] nv_default_demand_i,
  input  wire [15:0] nv_default_enable_i,
  input  wire        serial_rx_i,
  output wire        serial_tx_o,
  output reg         serial_drive_en_o,
  output reg         motor_run_o,
  output reg  [6:0]  drive_level_o,
  output reg  [10:0] test_level_o,
  output reg         status_lamp_o,
  output reg         external_status_lamp_o,
  output reg         line_activity_lamp_o,
  output reg         nv_save_o,
  output reg  [15:0] nv_default_demand_o,
  output reg  [15:0] nv_default_enable_o
);
  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function [15:0] crc8;
    input [15:0] c;
    input [7:0]  d;
    integer      k;
    reg   [15:0] x;
    begin
      x = c ^ {8'h00, d};
      for (k = 0; k < 8; k = k + 1) begin
        x = x[0] ? ((x >> 1) ^ `FMR_CRC_POLY) : (x >> 1);
      end
      crc8 = x;
    end
  endfunction

  function rd_ok;
    input [15:0] a;
    begin
      case (a)
        `FMR_REG_RUN, `FMR_REG_DEMAND, `FMR_REG_RPM, `FMR_REG_KNOB,
        `FMR_REG_STATUS, `FMR_REG_DEF_DEM, `FMR_REG_APPLIED,
        `FMR_REG_DEF_RUN, `FMR_REG_EXT_V: rd_ok = 1'b1;
        default: rd_ok = 1'b0;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Input synchronisers and power-up capture
  // ----------------------------------------------------------------
  reg [1:0]  mode_m, mode_s;
  reg [7:0]  addr_m, addr_s;
  reg        rx_m, rx_s;
  reg [1:0]  init_cnt;
  reg        ready;
  reg [7:0]  my_addr;
  reg [15:0] run_word, demand, def_demand, def_enable;

  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mode_m <= 2'h0;
      mode_s <= 2'h0;
      addr_m <= 8'h00;
      addr_s <= 8'h00;
      rx_m   <= 1'b1;
      rx_s   <= 1'b1;
      line_activity_lamp_o <= 1'b0;
    end else begin
      mode_m <= mode_switch_bank_i;
      mode_s <= mode_m;
      addr_m <= address_switch_bank_i;
      addr_s <= addr_m;
      rx_m   <= serial_rx_i;
      rx_s   <= rx_m;
      // The lamp bypasses the frame logic so a dead core cannot hide wiring faults.
      line_activity_lamp_o <= ~rx_s;
    end
  end

  wire net_mode = mode_s[1];
  wire ana_mode = mode_s[0] & ~mode_s[1];

  // ----------------------------------------------------------------
  // Demand sources
  // ----------------------------------------------------------------
  reg         ana_on;
  wire [9:0]  v_in   = external_voltage_reading_i;
  wire [9:0]  v_off  = (v_in > `FMR_ANA_BASE) ? (v_in - `FMR_ANA_BASE) : 10'h000;
  wire [16:0] v_prod = v_off * `FMR_ANA_GAIN;
  wire [16:0] v_quo  = v_prod / `FMR_ANA_SPAN;
  wire [6:0]  v_pct  = (v_quo >= 17'h00062) ? 7'h63 : (v_quo[6:0] + 7'h01);
  wire [9:0]  k_div  = knob_reading_i / 10'h00A;
  reg  [6:0]  next_level;
  reg         next_run;

  always @* begin
    if (net_mode) begin
      next_run   = run_word[0];
      next_level = run_word[0] ? demand[6:0] : 7'h00;
    end else if (ana_mode) begin
      next_run   = ana_on;
      next_level = !ana_on ? 7'h00 :
                   (v_in >= `FMR_ANA_FULL) ? 7'h64 : v_pct;
    end else begin
      next_run   = 1'b1;
      next_level = (k_div > 10'h064) ? 7'h64 : k_div[6:0];
    end
  end

  // Speed is floored to the step grid; values below one step read as stopped.
  wire [15:0] rpm_cap = (motor_rpm_i > `FMR_MAX_RPM) ? `FMR_MAX_RPM : motor_rpm_i;
  wire [15:0] rpm_q   = (rpm_cap / `FMR_RPM_STEP) * `FMR_RPM_STEP;
  wire [15:0] status  = {12'h000, ana_mode, net_mode, motor_run_o, status_lamp_o};

  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ana_on        <= 1'b0;
      motor_run_o   <= 1'b0;
      drive_level_o <= 7'h00;
      test_level_o  <= 11'h000;
      status_lamp_o <= 1'b0;
      external_status_lamp_o <= 1'b0;
    end else begin
      if (!ana_on && v_in > `FMR_ANA_ON)
        ana_on <= 1'b1;
      else if (ana_on && v_in < `FMR_ANA_OFF)
        ana_on <= 1'b0;
      motor_run_o   <= ready & next_run;
      drive_level_o <= ready ? next_level : 7'h00;
      status_lamp_o <= (rpm_q != 16'h0000);
      external_status_lamp_o <= (rpm_q != 16'h0000);
      if (!net_mode && !addr_s[0])
        test_level_o <= drive_level_o * 4'hA;
      else
        test_level_o <= rpm_q[10:0];
    end
  end

  // ----------------------------------------------------------------
  // Oversampling tick and receiver
  // ----------------------------------------------------------------
  reg [15:0] div_cnt;
  reg        tick;
  reg        rx_busy;
  reg [7:0]  rx_cnt;
  reg [7:0]  rx_sh;
  reg        rx_done;

  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      div_cnt <= 16'h0000;
      tick    <= 1'b0;
      rx_busy <= 1'b0;
      rx_cnt  <= 8'h00;
      rx_sh   <= 8'h00;
      rx_done <= 1'b0;
    end else begin
      tick    <= (div_cnt == TICK_DIV - 1);
      div_cnt <= (div_cnt == TICK_DIV - 1) ? 16'h0000 : div_cnt + 16'h0001;
      rx_done <= 1'b0;
      if (tick) begin
        if (!rx_busy) begin
          rx_busy <= ~rx_s;
          rx_cnt  <= 8'h00;
        end else begin
          rx_cnt <= rx_cnt + 8'h01;
          if (rx_cnt[3:0] == 4'h8) begin
            if (rx_cnt[7:4] == 4'h0 && rx_s)
              rx_busy <= 1'b0;
            else if (rx_cnt[7:4] >= 4'h1 && rx_cnt[7:4] <= 4'h8)
              rx_sh <= {rx_s, rx_sh[7:1]};
            else if (rx_cnt[7:4] == 4'h9) begin
              rx_busy <= 1'b0;
              rx_done <= rx_s;
            end
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Frame collection and decode
  // ----------------------------------------------------------------
  reg [7:0]  rxb [0:7];
  reg [3:0]  rx_n;
  reg [15:0] rx_crc;
  reg [15:0] sil_cnt;
  reg        tx_act;
  reg [7:0]  tx_i, tx_len, t_fn, t_exc;
  reg [15:0] t_ra, t_qty, tx_crc;
  reg [9:0]  tx_sh;
  reg [3:0]  tx_tk, tx_b;

  wire [7:0]  f_adr = rxb[0];
  wire [7:0]  f_fn  = rxb[1];
  wire [15:0] f_ra  = {rxb[2], rxb[3]};
  wire [15:0] f_val = {rxb[4], rxb[5]};
  wire        f_ok  = (rx_n == `FMR_REQ_LEN) && (rx_crc == 16'h0000) &&
                      (f_adr == my_addr || f_adr == 8'h00);
  wire        f_end = (sil_cnt == SIL_TICKS) && (rx_n != 4'h0) && tick;

  reg [7:0]  p_exc;
  reg [15:0] pa;
  integer    i;
  integer    n;

  always @* begin
    p_exc = 8'h00;
    pa    = f_ra;
    if (f_fn == `FMR_FN_READ) begin
      if (f_val == 16'h0000 || f_val > QMAX)
        p_exc = `FMR_EXC_VAL;
      else begin
        for (i = 0; i < QMAX; i = i + 1) begin
          if (i < f_val && !rd_ok(pa))
            p_exc = `FMR_EXC_ADDR;
          pa = pa + 16'h0001;
        end
      end
    end else if (f_fn == `FMR_FN_WRITE) begin
      case (f_ra)
        `FMR_REG_RUN:
          p_exc = (f_val > 16'h0001) ? `FMR_EXC_VAL : 8'h00;
        `FMR_REG_DEF_RUN:
          p_exc = (f_val > 16'h0001 && f_val != `FMR_FACTORY_KEY) ? `FMR_EXC_VAL : 8'h00;
        `FMR_REG_DEMAND, `FMR_REG_DEF_DEM:
          p_exc = (f_val > `FMR_MAX_PCT) ? `FMR_EXC_VAL : 8'h00;
        default:
          p_exc = `FMR_EXC_ADDR;
      endcase
    end else
      p_exc = `FMR_EXC_FN;
  end

  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rx_n    <= 4'h0;
      rx_crc  <= `FMR_CRC_INIT;
      sil_cnt <= 16'h0000;
      for (n = 0; n < 8; n = n + 1)
        rxb[n] <= 8'h00;
    end else begin
      if (rx_busy || !rx_s)
        sil_cnt <= 16'h0000;
      else if (tick && sil_cnt != SIL_TICKS)
        sil_cnt <= sil_cnt + 16'h0001;
      // Bytes heard while answering are dropped; the link is half duplex.
      if (rx_done && !tx_act && ready) begin
        if (rx_n < `FMR_REQ_LEN)
          rxb[rx_n[2:0]] <= rx_sh;
        if (rx_n <= `FMR_REQ_LEN)
          rx_n <= rx_n + 4'h1;
        rx_crc <= crc8(rx_crc, rx_sh);
      end else if (f_end) begin
        rx_n   <= 4'h0;
        rx_crc <= `FMR_CRC_INIT;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register bank, power-up load and writes
  // ----------------------------------------------------------------
  wire do_wr = f_end && f_ok && f_fn == `FMR_FN_WRITE && p_exc == 8'h00;

  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      init_cnt   <= 2'h0;
      ready      <= 1'b0;
      my_addr    <= 8'h00;
      run_word   <= 16'h0000;
      demand     <= 16'h0000;
      def_demand <= `FMR_DEF_DEMAND;
      def_enable <= `FMR_DEF_ENABLE;
      nv_save_o  <= 1'b0;
      nv_default_demand_o <= `FMR_DEF_DEMAND;
      nv_default_enable_o <= `FMR_DEF_ENABLE;
    end else begin
      nv_save_o <= 1'b0;
      if (!ready) begin
        init_cnt <= init_cnt + 2'h1;
        if (init_cnt == `FMR_SYNC_WAIT) begin
          ready   <= 1'b1;
          my_addr <= addr_s;
          if (nv_default_enable_i == `FMR_FACTORY_KEY) begin
            def_demand <= `FMR_DEF_DEMAND;
            def_enable <= `FMR_DEF_ENABLE;
            run_word   <= `FMR_DEF_ENABLE;
            demand     <= `FMR_DEF_DEMAND;
            nv_save_o  <= 1'b1;
            nv_default_demand_o <= `FMR_DEF_DEMAND;
            nv_default_enable_o <= `FMR_DEF_ENABLE;
          end else begin
            def_demand <= nv_default_demand_i;
            def_enable <= nv_default_enable_i;
            run_word   <= nv_default_enable_i;
            demand     <= nv_default_demand_i;
          end
        end
      end else if (do_wr) begin
        case (f_ra)
          `FMR_REG_RUN:    run_word <= f_val;
          `FMR_REG_DEMAND: demand   <= f_val;
          `FMR_REG_DEF_DEM: begin
            def_demand <= f_val;
            nv_default_demand_o <= f_val;
            nv_save_o <= 1'b1;
          end
          default: begin
            def_enable <= f_val;
            nv_default_enable_o <= f_val;
            nv_save_o <= 1'b1;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Reply transmitter
  // ----------------------------------------------------------------
  reg  [7:0]  tx_byte;
  reg  [15:0] tx_reg;
  reg  [15:0] tx_word;
  wire [7:0]  tx_j = tx_i - 8'h03;

  // Read mux kept out of a function so that every live source is in the sensitivity list.
  always @* begin
    case (tx_reg)
      `FMR_REG_RUN:     tx_word = run_word;
      `FMR_REG_DEMAND:  tx_word = demand;
      `FMR_REG_RPM:     tx_word = rpm_q;
      `FMR_REG_KNOB:    tx_word = {6'h00, knob_reading_i};
      `FMR_REG_STATUS:  tx_word = status;
      `FMR_REG_DEF_DEM: tx_word = def_demand;
      `FMR_REG_APPLIED: tx_word = {9'h000, drive_level_o};
      `FMR_REG_DEF_RUN: tx_word = def_enable;
      `FMR_REG_EXT_V:   tx_word = {6'h00, v_in};
      default:          tx_word = 16'h0000;
    endcase
  end

  always @* begin
    tx_reg = t_ra + {9'h000, tx_j[7:1]};
    if (tx_i == tx_len - 8'h02)
      tx_byte = tx_crc[7:0];
    else if (tx_i == tx_len - 8'h01)
      tx_byte = tx_crc[15:8];
    else if (tx_i == 8'h00)
      tx_byte = my_addr;
    else if (tx_i == 8'h01)
      tx_byte = (t_exc != 8'h00) ? (t_fn | `FMR_EXC_FLAG) : t_fn;
    else if (t_exc != 8'h00)
      tx_byte = t_exc;
    else if (t_fn == `FMR_FN_WRITE)
      tx_byte = rxb[tx_i[2:0]];
    else if (tx_i == 8'h02)
      tx_byte = {t_qty[6:0], 1'b0};
    else
      tx_byte = tx_j[0] ? tx_word[7:0] : tx_word[15:8];
  end

  assign serial_tx_o = tx_sh[0];

  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tx_act  <= 1'b0;
      tx_i    <= 8'h00;
      tx_len  <= 8'h00;
      t_fn    <= 8'h00;
      t_exc   <= 8'h00;
      t_ra    <= 16'h0000;
      t_qty   <= 16'h0000;
      tx_crc  <= `FMR_CRC_INIT;
      tx_sh   <= 10'h3FF;
      tx_tk   <= 4'h0;
      tx_b    <= 4'hA;
      serial_drive_en_o <= 1'b0;
    end else if (!tx_act) begin
      // Broadcasts are obeyed but never answered, so nodes do not collide.
      if (f_end && f_ok && f_adr != 8'h00) begin
        tx_act <= 1'b1;
        tx_i   <= 8'h00;
        tx_b   <= 4'hA;
        tx_crc <= `FMR_CRC_INIT;
        t_fn   <= f_fn;
        t_exc  <= p_exc;
        t_ra   <= f_ra;
        t_qty  <= f_val;
        serial_drive_en_o <= 1'b1;
        if (p_exc != 8'h00)
          tx_len <= `FMR_EXC_LEN;
        else if (f_fn == `FMR_FN_READ)
          tx_len <= 8'h05 + {f_val[6:0], 1'b0};
        else
          tx_len <= 8'h08;
      end
    end else if (tick) begin
      if (tx_b == 4'hA) begin
        if (tx_i == tx_len) begin
          tx_act <= 1'b0;
          serial_drive_en_o <= 1'b0;
        end else begin
          tx_sh <= {1'b1, tx_byte, 1'b0};
          if (tx_i < tx_len - 8'h02)
            tx_crc <= crc8(tx_crc, tx_byte);
          tx_i  <= tx_i + 8'h01;
          tx_b  <= 4'h0;
          tx_tk <= 4'h0;
        end
      end else begin
        tx_tk <= tx_tk + 4'h1;
        if (tx_tk == 4'hF) begin
          tx_sh <= {1'b1, tx_sh[9:1]};
          tx_b  <= tx_b + 4'h1;
        end
      end
    end
  end

endmodule

// File: fmr_core_asserts.sv
`timescale 1ns/1ps
module fmr_core_asserts #(
  parameter TICK_DIV  = 4,
  parameter SIL_TICKS = 40,
  parameter QMAX      = 16
) (
  input wire        clk_sys_i,
  input wire        reset_n_i,
  input wire [1:0]  mode_switch_bank_i,
  input wire [7:0]  address_switch_bank_i,
  input wire [9:0]  knob_reading_i,
  input wire [9:0]  external_voltage_reading_i,
  input wire [15:0] motor_rpm_i,
  input wire [15:0] nv_default_demand_i,
  input wire [15:0] nv_default_enable_i,
  input wire        serial_rx_i,
  input wire        serial_tx_o,
  input wire        serial_drive_en_o,
  input wire        motor_run_o,
  input wire [6:0]  drive_level_o,
  input wire [10:0] test_level_o,
  input wire        status_lamp_o,
  input wire        external_status_lamp_o,
  input wire        line_activity_lamp_o,
  input wire        nv_save_o,
  input wire [15:0] nv_default_demand_o,
  input wire [15:0] nv_default_enable_o
);
  // ----------
  // Idle time of the receive line
  // ----------
  reg [15:0] idle_cnt;
  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i)
      idle_cnt <= 16'h0000;
    else if (!serial_rx_i)
      idle_cnt <= 16'h0000;
    else if (idle_cnt != 16'hFFFF)
      idle_cnt <= idle_cnt + 16'h0001;
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  // ----------
  // Properties
  // ----------
  property p_line_lamp;
    $past(reset_n_i, 4) |-> line_activity_lamp_o == !$past(serial_rx_i, 3);
  endproperty
  a_line_lamp: assert property (p_line_lamp) else $error("line lamp off its receive line");
  property p_ext_lamp;
    external_status_lamp_o == status_lamp_o;
  endproperty
  a_ext_lamp: assert property (p_ext_lamp) else $error("external lamp differs");
  property p_lamp_rpm;
    $stable(motor_rpm_i)[*8] |-> status_lamp_o == (motor_rpm_i >= 16'h0005);
  endproperty
  a_lamp_rpm: assert property (p_lamp_rpm) else $error("status lamp wrong for speed");
  property p_drive_max;
    drive_level_o <= 7'h64;
  endproperty
  a_drive_max: assert property (p_drive_max) else $error("drive level above 100");
  property p_test_max;
    test_level_o <= 11'h7D0;
  endproperty
  a_test_max: assert property (p_test_max) else $error("test level above 2000");
  property p_tx_idle;
    !serial_drive_en_o |-> serial_tx_o;
  endproperty
  a_tx_idle: assert property (p_tx_idle) else $error("transmit line not idle high");
  property p_save_pulse;
    nv_save_o |=> !nv_save_o;
  endproperty
  a_save_pulse: assert property (p_save_pulse) else $error("save strobe too long");
  property p_silence;
    $rose(serial_drive_en_o) |-> idle_cnt >= (SIL_TICKS - 1) * TICK_DIV;
  endproperty
  a_silence: assert property (p_silence) else $error("reply before line silence");
  property p_start_bit;
    $rose(serial_drive_en_o) |-> ##[1:12] !serial_tx_o;
  endproperty
  a_start_bit: assert property (p_start_bit) else $error("no start bit after enable");
  property p_knob;
    (mode_switch_bank_i == 2'b00 && $stable(knob_reading_i) && $stable(mode_switch_bank_i))[*8]
      |-> drive_level_o == (knob_reading_i >= 10'h3E8 ? 10'h064 : knob_reading_i / 10'h00A);
  endproperty
  a_knob: assert property (p_knob) else $error("knob mode drive level wrong");
endmodule

bind fmr_core fmr_core_asserts #(.TICK_DIV(TICK_DIV), .SIL_TICKS(SIL_TICKS), .QMAX(QMAX)) u_asserts (
  .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .mode_switch_bank_i(mode_switch_bank_i),
  .address_switch_bank_i(address_switch_bank_i), .knob_reading_i(knob_reading_i),
  .external_voltage_reading_i(external_voltage_reading_i), .motor_rpm_i(motor_rpm_i),
  .nv_default_demand_i(nv_default_demand_i), .nv_default_enable_i(nv_default_enable_i),
  .serial_rx_i(serial_rx_i), .serial_tx_o(serial_tx_o), .serial_drive_en_o(serial_drive_en_o),
  .motor_run_o(motor_run_o), .drive_level_o(drive_level_o), .test_level_o(test_level_o),
  .status_lamp_o(status_lamp_o), .external_status_lamp_o(external_status_lamp_o),
  .line_activity_lamp_o(line_activity_lamp_o), .nv_save_o(nv_save_o),
  .nv_default_demand_o(nv_default_demand_o), .nv_default_enable_o(nv_default_enable_o));

// File: fmr_master_model.sv
`timescale 1ns/1ps
`include "fmr_map.vh"
module fmr_master_model #(
  parameter BIT = 64
) (
  input  wire clk_i,
  input  wire tx_line_i,
  input  wire drive_en_i,
  output reg  rx_line_o
);
  byte unsigned reply[$];
  initial rx_line_o = 1'b1;
  function automatic [15:0] crc16(input byte unsigned q[$]);
    logic [15:0] c;
    c = `FMR_CRC_INIT;
    foreach (q[i]) begin
      c = c ^ q[i];
      for (int b = 0; b < 8; b++)
        c = c[0] ? (c >> 1) ^ `FMR_CRC_POLY : c >> 1;
    end
    return c;
  endfunction
  // One start bit, eight data bits first bit lowest, one stop bit.
  task automatic put_byte(input byte unsigned v);
    logic [9:0] f;
    f = {1'b1, v, 1'b0};
    for (int k = 0; k < 10; k++) begin
      rx_line_o <= f[k];
      repeat (BIT) @(posedge clk_i);
    end
  endtask
  task automatic send(input byte unsigned q[$]);
    logic [15:0] c;
    c = crc16(q);
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    @(posedge clk_i);
    foreach (q[i]) put_byte(q[i]);
  endtask
  // Bytes are sampled mid-bit so edge jitter of the slave cannot mislead.
  task automatic recv();
    byte unsigned v;
    int t;
    reply.delete();
    t = 0;
    while (!drive_en_i && t < 400) begin
      @(posedge clk_i);
      t++;
    end
    t = 0;
    while (drive_en_i && t < 20000) begin
      @(posedge clk_i);
      t++;
      if (!tx_line_i) begin
        repeat (BIT / 2) @(posedge clk_i);
        for (int k = 0; k < 8; k++) begin
          repeat (BIT) @(posedge clk_i);
          v[k] = tx_line_i;
        end
        reply.push_back(v);
        repeat (BIT) @(posedge clk_i);
      end
    end
  endtask
endmodule

// File: fan_motor_mode_and_register_slave_bench.sv
`timescale 1ns/1ps
`include "fmr_map.vh"
module fan_motor_mode_and_register_slave_bench;
  reg         clk_sys_i = 1'b0;
  reg         reset_n_i = 1'b0;
  reg  [1:0]  mode      = 2'b10;
  reg  [7:0]  addr      = 8'h11;
  reg  [9:0]  knob      = 10'h1F4;
  reg  [9:0]  ext_v     = 10'h2EE;
  reg  [15:0] rpm       = 16'h0387;
  reg  [15:0] nv_dem    = 16'h0037;
  reg  [15:0] nv_en     = 16'h0000;
  wire        rx;
  wire        tx;
  wire        den;
  wire        run;
  wire        lamp;
  wire        xlamp;
  wire        save;
  wire [6:0]  drive;
  wire [10:0] test;
  wire [15:0] nve;
  wire [15:0] nvd;
  integer     bad_count = 0;
  integer     tests_run = 0;
  always #2 clk_sys_i = ~clk_sys_i;
  fmr_core #(.TICK_DIV(4), .SIL_TICKS(40)) dut (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .mode_switch_bank_i(mode),
    .address_switch_bank_i(addr), .knob_reading_i(knob), .external_voltage_reading_i(ext_v),
    .motor_rpm_i(rpm), .nv_default_demand_i(nv_dem), .nv_default_enable_i(nv_en),
    .serial_rx_i(rx), .serial_tx_o(tx), .serial_drive_en_o(den), .motor_run_o(run),
    .drive_level_o(drive), .test_level_o(test), .status_lamp_o(lamp),
    .external_status_lamp_o(xlamp), .line_activity_lamp_o(), .nv_save_o(save),
    .nv_default_demand_o(nvd), .nv_default_enable_o(nve));
  fmr_master_model #(.BIT(64)) master (.clk_i(clk_sys_i), .tx_line_i(tx), .drive_en_i(den), .rx_line_o(rx));
  // ----------
  // Shared tasks
  // ----------
  task check(input [15:0] got, input [15:0] exp);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input [7:0] a, input [7:0] f, input [15:0] r, input [15:0] v, input [15:0] n);
    master.send('{a, f, r[15:8], r[7:0], v[15:8], v[7:0]});
    master.recv();
    // Ending on a falling edge keeps later stimulus and checks off the sampling edge.
    @(negedge clk_sys_i);
    check(16'(master.reply.size()), n);
    if (n != 16'h0000)
      check(master.crc16(master.reply), 16'h0000);
  endtask
  function [15:0] word(input int i);
    return {master.reply[i], master.reply[i+1]};
  endfunction
  task settle;
    repeat (8) @(negedge clk_sys_i);
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ----------
  // Sequence
  // ----------
  initial begin
    repeat (16) @(negedge clk_sys_i);
    reset_n_i = 1'b1;
    repeat (10) @(negedge clk_sys_i);
    addr = 8'h22;
    xfer(8'h11, `FMR_FN_READ, `FMR_REG_DEMAND, 16'h0001, 16'h0007);
    check(word(3), 16'h0037);
    check({9'h000, drive}, 16'h0000);
    check({15'h0000, run}, 16'h0000);
    xfer(8'h11, `FMR_FN_WRITE, `FMR_REG_RUN, 16'h0001, 16'h0008);
    check(word(4), 16'h0001);
    check({9'h000, drive}, 16'h0037);
    check({15'h0000, run}, 16'h0001);
    xfer(8'h11, `FMR_FN_READ, `FMR_REG_APPLIED, 16'h0001, 16'h0007);
    check(word(3), 16'h0037);
    xfer(8'h11, `FMR_FN_READ, `FMR_REG_RPM, 16'h0001, 16'h0007);
    check(word(3), 16'h0384);
    check({5'h00, test}, 16'h0384);
    check({14'h0000, lamp, xlamp}, 16'h0003);
    xfer(8'h11, `FMR_FN_READ, `FMR_REG_EXT_V, 16'h0001, 16'h0007);
    check(word(3), 16'h02EE);
    $display("test network done");
    xfer(8'h11, `FMR_FN_WRITE, `FMR_REG_RPM, 16'h0005, 16'h0005);
    check(master.reply[1], `FMR_EXC_FLAG | `FMR_FN_WRITE);
    check(master.reply[2], `FMR_EXC_ADDR);
    xfer(8'h00, `FMR_FN_WRITE, `FMR_REG_DEMAND, 16'h0014, 16'h0000);
    check({9'h000, drive}, 16'h0014);
    xfer(8'h11, `FMR_FN_WRITE, `FMR_REG_DEF_RUN, `FMR_FACTORY_KEY, 16'h0008);
    check(nve, `FMR_FACTORY_KEY);
    $display("test errors done");
    nv_en = `FMR_FACTORY_KEY;
    reset_n_i = 1'b0;
    repeat (16) @(negedge clk_sys_i);
    reset_n_i = 1'b1;
    repeat (4) @(negedge clk_sys_i);
    check({7'h00, save, nvd[7:0]}, 16'h0132);
    settle;
    check({9'h000, drive}, 16'h0032);
    check(nve, `FMR_DEF_ENABLE);
    $display("test restore done");
    mode = 2'b00;
    settle;
    check({9'h000, drive}, 16'h0032);
    check({5'h00, test}, 16'h01F4);
    addr = 8'h23;
    settle;
    check({5'h00, test}, 16'h0384);
    mode = 2'b01;
    ext_v = 10'h3E8;
    settle;
    check({9'h000, drive}, 16'h0064);
    ext_v = 10'h000;
    settle;
    check({9'h000, drive}, 16'h0000);
    check({15'h0000, run}, 16'h0000);
    mode = 2'b11;
    settle;
    check({9'h000, drive}, 16'h0032);
    $display("test modes done");
    give_verdict;
  end
  initial begin
    repeat (95000) @(posedge clk_sys_i);
    bad_count = bad_count + 1;
    give_verdict;
  end
endmodule
